// [channel_test_decode.sv]
// One channel's test control register and its datapath steering.
`timescale 1ns/10ps
`default_nettype none
module channel_test_decode #(
   parameter bit IS_CHAN0 = 1'b0
) (
   // Clock and reset.
   input  wire logic                       i_clk,
   input  wire logic                       i_reset_n,
   // Register write.
   input  wire logic                       i_wr,
   input  wire logic [15:0]                i_wdata,
   // Channel timing strobes.
   input  wire logic                       i_symbol_strobe,
   input  wire logic                       i_sample_strobe,
   input  wire logic                       i_edge_strobe,
   // Register value and decoded controls.
   output logic [15:0]                     o_reg,
   output test_mode_pkg::chan_ctrl_t       o_ctrl
);
   import test_mode_pkg::*;

   typedef struct packed {
      logic [15:0] test_r;
      chan_ctrl_t  ctrl_r;
   } state_t;

   localparam logic [15:0] KEEP_MASK = IS_CHAN0 ? (TEST_CHN_MASK | TEST_CH0_MASK) : TEST_CHN_MASK;

   state_t st_r;
   state_t st_nxt;

   // Controls are registered so the channel sees them one clock after the strobes.
   always_comb begin
      st_nxt = st_r;
      if (i_wr) begin
         st_nxt.test_r = i_wdata & KEEP_MASK; // RQ7 RQ12
      end
      st_nxt.ctrl_r.pn_enable     = st_nxt.test_r[TEST_PN_EN];
      st_nxt.ctrl_r.pn_source     = st_nxt.test_r[TEST_SEL_PN]; // RQ1
      st_nxt.ctrl_r.pn_step       = st_nxt.test_r[TEST_PN_EN] &
                                    (st_nxt.test_r[TEST_PN_RATE] | i_symbol_strobe); // RQ2
      st_nxt.ctrl_r.straight_thru = st_nxt.test_r[TEST_STRAIGHT]; // RQ3
      st_nxt.ctrl_r.filter_shift  = st_nxt.test_r[TEST_FORCE_EDGE] | i_edge_strobe; // RQ4
      st_nxt.ctrl_r.fifo_pop      = st_nxt.test_r[TEST_FORCE_FIFO] | i_sample_strobe; // RQ5
      st_nxt.ctrl_r.carrier_force = st_nxt.test_r[TEST_CARRIER]; // RQ6
   end

   // Single register stage holds all channel state.
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_r <= '{test_r: TEST_RESET, ctrl_r: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_reg  = st_r.test_r;
   assign o_ctrl = st_r.ctrl_r;

   AST_FORCE_POP: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ5
      st_r.test_r[TEST_FORCE_FIFO] && !i_wr |=> st_r.ctrl_r.fifo_pop)
      else $error("Forced FIFO pop missing.");
   AST_PN_CLOCK_RATE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ2
      (st_r.test_r[TEST_PN_EN] && st_r.test_r[TEST_PN_RATE] && !i_wr) |=> st_r.ctrl_r.pn_step)
      else $error("Noise generator did not step at clock rate.");
   AST_PN_SYMBOL_RATE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ2
      (!st_r.test_r[TEST_PN_RATE] && !i_symbol_strobe && !i_wr) |=> !st_r.ctrl_r.pn_step)
      else $error("Noise generator stepped without a symbol.");
   AST_FORCE_EDGE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ4
      st_r.test_r[TEST_FORCE_EDGE] && !i_wr |=> st_r.ctrl_r.filter_shift)
      else $error("Forced filter shift missing.");
   AST_CH0_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ7
      IS_CHAN0 || ((st_r.test_r & TEST_CH0_MASK) == 16'h0000))
      else $error("Channel-0 test bits set in another channel.");
endmodule
`default_nettype wire

// [test_and_output_mode_control_tb_top.sv]
// Self-checking testbench for the test and output mode control register bank.
`timescale 1ns/10ps
`default_nettype none
module test_and_output_mode_control_tb_top;
   import test_mode_pkg::*;
   logic             core_clk;
   logic             reset_n;
   cpu_req_t         req;
   logic [15:0]      rdata;
   logic [3:0]       sym_stb;
   logic [3:0]       smp_stb;
   logic [3:0]       edg_stb;
   chan_ctrl_t [3:0] chan_ctrl;
   logic [17:0]      carrier;
   logic             self_test;
   logic [1:0]       out_mode;
   logic             dbl_mux;
   logic [15:0]      routing;
   int               err_total;
   int               tests_run;

   // Device under test with the default synchronisation length.
   test_output_mode_ctrl u_test_output_mode_ctrl (
      .I_CORE_CLK        (core_clk),
      .I_RESET_N         (reset_n),
      .I_CPU_REQ         (req),
      .O_RDATA           (rdata),
      .I_SYMBOL_STROBE   (sym_stb),
      .I_SAMPLE_STROBE   (smp_stb),
      .I_EDGE_STROBE     (edg_stb),
      .O_CHAN_CTRL       (chan_ctrl),
      .O_CARRIER_FORCED  (carrier),
      .O_SELF_TEST       (self_test),
      .O_OUTPUT_MODE     (out_mode),
      .O_DOUBLE_RATE_MUX (dbl_mux),
      .O_ROUTING_ACTIVE  (routing)
   );

   // Clock at 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Compares one value; case inequality so an unknown never passes.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // A leading idle edge keeps two requests from being assigned in one time step.
   task automatic wr(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] d);
      cyc(1);
      req <= '{wr: 1'b1, rd: 1'b0, chan: ch, addr: a, data: d};
      cyc(1);
      req <= '0;
   endtask

   // Read data is registered at the taking edge and stands for one cycle.
   task automatic rd(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] exp);
      cyc(1);
      req <= '{wr: 1'b0, rd: 1'b1, chan: ch, addr: a, data: 16'h0000};
      cyc(1);
      req <= '0;
      chk("read data", exp, rdata);
   endtask

   task automatic sc_reset();
      chk("ctrl in reset", 28'h0, chan_ctrl);
      chk("self test in reset", 1'b0, self_test);
      reset_n <= 1'b1;
      rd(2'h0, ADDR_DEV_CTRL, 16'h0000);
      rd(2'h0, ADDR_TEST_CTRL, 16'h0000);
      rd(2'h0, 7'h00, 16'h0000);
      chk("carrier value", 18'h1ffff, carrier);
   endtask

   task automatic sc_test_bits();
      wr(2'h0, ADDR_TEST_CTRL, 16'h00ff);
      wr(2'h1, ADDR_TEST_CTRL, 16'h00ff);
      rd(2'h0, ADDR_TEST_CTRL, 16'h00df);
      rd(2'h1, ADDR_TEST_CTRL, 16'h005f);
      chk("ctrl ch0", 7'h7f, chan_ctrl[0]);
      chk("ctrl ch1", 7'h2f, chan_ctrl[1]);
      chk("ctrl ch2", 7'h00, chan_ctrl[2]);
   endtask

   // Each strobe alone must give exactly one step, then the force bits give one every clock.
   task automatic sc_strobes();
      int n;
      wr(2'h0, ADDR_TEST_CTRL, 16'h0080);
      cyc(3);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         sym_stb[0] <= (k == 0);
         smp_stb[0] <= (k == 1);
         edg_stb[0] <= (k == 2);
         cyc(1);
         sym_stb <= 4'h0;
         smp_stb <= 4'h0;
         edg_stb <= 4'h0;
         for (int j = 0; j < 5; j++) begin
            n += (k == 0) ? chan_ctrl[0].pn_step : (k == 1) ? chan_ctrl[0].fifo_pop : chan_ctrl[0].filter_shift;
            cyc(1);
         end
         chk("single step count", 1, n);
      end
      wr(2'h0, ADDR_TEST_CTRL, 16'h00c6);
      wr(2'h1, ADDR_TEST_CTRL, 16'h00c6);
      cyc(2);
      for (int j = 0; j < 4; j++) begin
         chk("forced ch0", 3'h7, {chan_ctrl[0].pn_step, chan_ctrl[0].fifo_pop, chan_ctrl[0].filter_shift});
         chk("forced ch1", 3'h3, {chan_ctrl[1].pn_step, chan_ctrl[1].fifo_pop, chan_ctrl[1].filter_shift});
         cyc(1);
      end
   endtask

   task automatic sc_dev_modes();
      for (int m = 0; m < 4; m++) begin
         wr(2'h0, ADDR_DEV_CTRL, 16'h4400 | (16'(m) << 8));
         cyc(3);
         chk("output mode", m[1:0], out_mode);
         chk("double rate", (m == 1), dbl_mux);
         chk("self test on", 1'b1, self_test);
      end
      wr(2'h0, ADDR_DEV_CTRL, 16'h0000);
      cyc(3);
      chk("self test off", 1'b0, self_test);
      wr(2'h0, ADDR_DEV_CTRL, 16'hffff);
      rd(2'h0, ADDR_DEV_CTRL, 16'hc7ff);
      cyc(2);
      chk("double rate mode 3", 1'b0, dbl_mux);
   endtask

   // Without immediate update the slave copy must still hold its reset value after the readback and eight idle clocks.
   task automatic sc_routing();
      wr(2'h0, ADDR_DEV_CTRL, 16'h0000);
      wr(2'h0, ADDR_ROUTING, 16'h1234);
      rd(2'h0, ADDR_ROUTING, 16'h1234);
      cyc(8);
      chk("routing held", 16'h0000, routing);
      wr(2'h0, ADDR_DEV_CTRL, 16'h8000);
      cyc(3);
      wr(2'h0, ADDR_ROUTING, 16'ha5c3);
      cyc(SYNC_CYCLES - 1);
      chk("routing early", 16'h0000, routing);
      cyc(1);
      chk("routing loaded", 16'ha5c3, routing);
   endtask

   // Broadcast sends one test write to every channel; channels 1 to 3 still drop bits 10 to 7.
   task automatic sc_broadcast();
      wr(2'h0, ADDR_DEV_CTRL, 16'h0001);
      wr(2'h2, ADDR_TEST_CTRL, 16'h00c4);
      rd(2'h0, ADDR_TEST_CTRL, 16'h00c4);
      rd(2'h3, ADDR_TEST_CTRL, 16'h0044);
      wr(2'h0, ADDR_DEV_CTRL, 16'h0000);
      wr(2'h1, ADDR_TEST_CTRL, 16'h0001);
      rd(2'h1, ADDR_TEST_CTRL, 16'h0001);
      rd(2'h3, ADDR_TEST_CTRL, 16'h0044);
   endtask

   task automatic wrap_up();
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      reset_n = 1'b0;
      req = '0;
      sym_stb = 4'h0;
      smp_stb = 4'h0;
      edg_stb = 4'h0;
      err_total = 0;
      tests_run = 0;
      cyc(16);
      sc_reset();
      sc_test_bits();
      sc_strobes();
      sc_dev_modes();
      sc_routing();
      sc_broadcast();
      wrap_up();
   end
endmodule
`default_nettype wire

// [test_mode_pkg.sv]
// Package with offsets, field positions, reset values and timing constants for the test and output mode control.
// How it works
// RQ1: Noise source select bit feeds the channel FIFO from the pseudo-noise generator.
// RQ2: Noise generator steps every clock when rate bit is one, else per symbol.
// RQ3: Straight-through bit sends FIFO samples directly to the interpolation filter.
// RQ4: Force-edge bit shifts shaping and interpolation filters every clock.
// RQ5: Force-FIFO bit pops a FIFO sample every clock.
// RQ6: Force-carrier bit holds sine and cosine outputs at 0x1ffff.
// RQ7: Test bits 10 to 7 work only in channel 0; elsewhere held zero.
// RQ8: Immediate update copies routing master to slave after four-clock synchronisation.
// RQ9: Self-test bit one enters built-in self-test; zero, the reset value, disables it.
// RQ10: Mode 01 with double-rate bit multiplexes I high-phase and Q low-phase.
// RQ11: Two-bit output mode field selects cascade, four I, four Q or muxed.
// RQ12: Reserved bits of both control registers ignore writes and read zero.
package test_mode_pkg;
   localparam logic [6:0]  ADDR_TEST_CTRL  = 7'h17;
   localparam logic [6:0]  ADDR_DEV_CTRL   = 7'h78;
   localparam logic [6:0]  ADDR_ROUTING    = 7'h79;
   localparam int          TEST_CARRIER    = 0;
   localparam int          TEST_FORCE_FIFO = 1;
   localparam int          TEST_FORCE_EDGE = 2;
   localparam int          TEST_SEL_PN     = 3;
   localparam int          TEST_STRAIGHT   = 4;
   localparam int          TEST_PN_RATE    = 6;
   localparam int          TEST_PN_EN      = 7;
   localparam int          DEV_MODE_LO     = 8;
   localparam int          DEV_DOUBLE_RATE = 10;
   localparam int          DEV_SELF_TEST   = 14;
   localparam int          DEV_IMMEDIATE   = 15;
   // Writable bits; everything else is reserved.
   localparam logic [15:0] TEST_LOW_MASK   = 16'h00df;
   localparam logic [15:0] TEST_CH0_MASK   = 16'h0780;
   localparam logic [15:0] TEST_CHN_MASK   = 16'h005f;
   localparam logic [15:0] DEV_WR_MASK     = 16'hc7ff;
   localparam logic [15:0] TEST_RESET      = 16'h0000;
   localparam logic [15:0] DEV_RESET       = 16'h0000;
   localparam logic [15:0] ROUTING_RESET   = 16'h0000;
   localparam logic [17:0] CARRIER_FORCED  = 18'h1ffff;
   localparam int          SYNC_CYCLES     = 4;
   localparam int          NUM_CHANNELS    = 4;
   localparam logic [1:0]  MODE_CASCADE    = 2'h0;
   localparam logic [1:0]  MODE_FOUR_I     = 2'h1;
   localparam logic [1:0]  MODE_FOUR_Q     = 2'h2;
   localparam logic [1:0]  MODE_MUXED      = 2'h3;

   // Per-channel controls decoded from a test register.
   typedef struct packed {
      logic pn_enable;
      logic pn_source;
      logic pn_step;
      logic straight_thru;
      logic filter_shift;
      logic fifo_pop;
      logic carrier_force;
   } chan_ctrl_t;

   // Processor port request.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  chan;
      logic [6:0]  addr;
      logic [15:0] data;
   } cpu_req_t;
endpackage

// [test_output_mode_ctrl.sv]
// Test and output mode control register bank for four channels.
`timescale 1ns/10ps
`default_nettype none
module test_output_mode_ctrl #(
   parameter int SYNC_LEN = test_mode_pkg::SYNC_CYCLES
) (
   // Clock and reset.
   input  wire logic                                    I_CORE_CLK,
   input  wire logic                                    I_RESET_N,
   // Processor port, already synchronised to the core clock.
   input  wire test_mode_pkg::cpu_req_t                 I_CPU_REQ,
   output logic [15:0]                                  O_RDATA,
   // Channel timing strobes.
   input  wire logic [3:0]                              I_SYMBOL_STROBE,
   input  wire logic [3:0]                              I_SAMPLE_STROBE,
   input  wire logic [3:0]                              I_EDGE_STROBE,
   // Channel steering.
   output test_mode_pkg::chan_ctrl_t [3:0]              O_CHAN_CTRL,
   output logic [17:0]                                  O_CARRIER_FORCED,
   // Device-level controls.
   output logic                                         O_SELF_TEST,
   output logic [1:0]                                   O_OUTPUT_MODE,
   output logic                                         O_DOUBLE_RATE_MUX,
   output logic [15:0]                                  O_ROUTING_ACTIVE
);
   import test_mode_pkg::*;

   typedef struct packed {
      logic [15:0] dev_r;
      logic [15:0] route_master_r;
      logic [15:0] route_slave_r;
      logic [2:0]  sync_cnt_r;
      logic        sync_busy_r;
      logic [15:0] rdata_r;
      logic        self_test_r;
      logic [1:0]  mode_r;
      logic        dbl_r;
   } state_t;

   state_t              st_r;
   state_t              st_nxt;
   logic [3:0]          test_wr;
   logic [15:0]         test_reg [NUM_CHANNELS];
   chan_ctrl_t [3:0]    chan_ctrl;

   // Decode a direct address for the addressed channel.
   function automatic logic hit(input logic [6:0] a, input logic [6:0] want);
      return a == want;
   endfunction

   // One decoder per channel; only channel 0 keeps the extra test bits.
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_chan
         assign test_wr[g] = I_CPU_REQ.wr && hit(I_CPU_REQ.addr, ADDR_TEST_CTRL) &&
                             (I_CPU_REQ.chan == 2'(g) || st_r.dev_r[0]);
         channel_test_decode #(.IS_CHAN0(g == 0)) u_dec (
            .i_clk           (I_CORE_CLK),
            .i_reset_n       (I_RESET_N),
            .i_wr            (test_wr[g]),
            .i_wdata         (I_CPU_REQ.data),
            .i_symbol_strobe (I_SYMBOL_STROBE[g]),
            .i_sample_strobe (I_SAMPLE_STROBE[g]),
            .i_edge_strobe   (I_EDGE_STROBE[g]),
            .o_reg           (test_reg[g]),
            .o_ctrl          (chan_ctrl[g])
         );
      end
   endgenerate

   // Register writes, routing update and readback. The slave copy loads only when a count
   // started by a routing write with immediate update set runs out; no other update of it exists.
   always_comb begin
      st_nxt = st_r;
      if (I_CPU_REQ.wr && hit(I_CPU_REQ.addr, ADDR_DEV_CTRL)) begin
         st_nxt.dev_r = I_CPU_REQ.data & DEV_WR_MASK; // RQ12
      end
      if (I_CPU_REQ.wr && hit(I_CPU_REQ.addr, ADDR_ROUTING)) begin
         st_nxt.route_master_r = I_CPU_REQ.data;
         if (st_r.dev_r[DEV_IMMEDIATE]) begin
            st_nxt.sync_busy_r = 1'b1; // RQ8
            st_nxt.sync_cnt_r  = 3'h0;
         end
      end else if (st_r.sync_busy_r) begin
         if (st_r.sync_cnt_r == 3'(SYNC_LEN - 1)) begin
            st_nxt.sync_busy_r   = 1'b0;
            st_nxt.route_slave_r = st_r.route_master_r; // RQ8
         end else begin
            st_nxt.sync_cnt_r = st_r.sync_cnt_r + 3'h1;
         end
      end
      st_nxt.self_test_r = st_nxt.dev_r[DEV_SELF_TEST]; // RQ9
      st_nxt.mode_r      = st_nxt.dev_r[DEV_MODE_LO +: 2]; // RQ11
      st_nxt.dbl_r       = st_nxt.dev_r[DEV_DOUBLE_RATE] &&
                           (st_nxt.dev_r[DEV_MODE_LO +: 2] == MODE_FOUR_I); // RQ10
      st_nxt.rdata_r = 16'h0000;
      if (I_CPU_REQ.rd) begin
         case (I_CPU_REQ.addr)
            ADDR_TEST_CTRL: st_nxt.rdata_r = test_reg[I_CPU_REQ.chan];
            ADDR_DEV_CTRL:  st_nxt.rdata_r = st_r.dev_r; // RQ12
            ADDR_ROUTING:   st_nxt.rdata_r = st_r.route_master_r;
            default:        st_nxt.rdata_r = 16'h0000;
         endcase
      end
   end

   // Single register stage for all device state.
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RESET_N) begin
         st_r <= '{dev_r: DEV_RESET, route_master_r: ROUTING_RESET, route_slave_r: ROUTING_RESET,
                   sync_cnt_r: 3'h0, sync_busy_r: 1'b0, rdata_r: 16'h0000, self_test_r: 1'b0,
                   mode_r: MODE_CASCADE, dbl_r: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops, except O_CARRIER_FORCED, which is a constant.
   assign O_RDATA           = st_r.rdata_r;
   assign O_CHAN_CTRL       = chan_ctrl;
   assign O_CARRIER_FORCED  = CARRIER_FORCED; // RQ6
   assign O_SELF_TEST       = st_r.self_test_r;
   assign O_OUTPUT_MODE     = st_r.mode_r;
   assign O_DOUBLE_RATE_MUX = st_r.dbl_r;
   assign O_ROUTING_ACTIVE  = st_r.route_slave_r;

   AST_IMMEDIATE_UPDATE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RQ8
      (I_CPU_REQ.wr && I_CPU_REQ.addr == ADDR_ROUTING && st_r.dev_r[DEV_IMMEDIATE]) ##1
      (!(I_CPU_REQ.wr && I_CPU_REQ.addr == ADDR_ROUTING))[*4]
      |=> (O_ROUTING_ACTIVE == $past(st_r.route_master_r)))
      else $error("Routing slave not loaded after four clocks.");
   AST_SELF_TEST: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RQ9
      (I_CPU_REQ.wr && I_CPU_REQ.addr == ADDR_DEV_CTRL) |=> (O_SELF_TEST == $past(I_CPU_REQ.data[DEV_SELF_TEST])))
      else $error("Self-test output does not follow control bit.");
   AST_DOUBLE_RATE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RQ10
      O_DOUBLE_RATE_MUX |-> O_OUTPUT_MODE == MODE_FOUR_I)
      else $error("Double-rate mux outside mode 01.");
   AST_MODE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RQ11
      (I_CPU_REQ.wr && I_CPU_REQ.addr == ADDR_DEV_CTRL) |=> (O_OUTPUT_MODE == $past(I_CPU_REQ.data[DEV_MODE_LO +: 2])))
      else $error("Output mode does not follow written field.");
   AST_RESERVED: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RQ12
      (st_r.dev_r & ~DEV_WR_MASK) == 16'h0000)
      else $error("Reserved device control bits set.");
endmodule
`default_nettype wire
